//--- verilog/hasrx_cfg.svh
// offsets, field positions, reset values and codes of the haptic audio serial receiver
`ifndef HASRX_CFG_SVH
`define HASRX_CFG_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define HASRX_AW 8
`define HASRX_DW 32
`define HASRX_ADDR_FORMAT 8'h52
`define HASRX_ADDR_WIDTH 8'h53
`define HASRX_ADDR_CTRL 8'h54
`define HASRX_ADDR_STATUS 8'h55
`define HASRX_ADDR_SAMPLE 8'h56
`define HASRX_ADDR_COUNT 8'h57

// ----------------------------------------------------------------------------
// audio_format_config fields
// ----------------------------------------------------------------------------
`define HASRX_FMT_W 15
`define HASRX_FMT_RESET 15'h0000
`define HASRX_FMT_TDM 0
`define HASRX_FMT_ALIGN 1
`define HASRX_FMT_SEL_LSB 4
`define HASRX_FMT_SEL_MSB 6
`define HASRX_FMT_NSLOT_LSB 8
`define HASRX_FMT_NSLOT_MSB 10
`define HASRX_FMT_RATE_LSB 12
`define HASRX_FMT_RATE_MSB 14

// ----------------------------------------------------------------------------
// audio_width_config fields
// ----------------------------------------------------------------------------
`define HASRX_WID_W 4
`define HASRX_WID_RESET 4'h0
`define HASRX_WID_SW_LSB 0
`define HASRX_WID_SW_MSB 1
`define HASRX_WID_SLEN_LSB 2
`define HASRX_WID_SLEN_MSB 3

// ----------------------------------------------------------------------------
// control and status fields, codes
// ----------------------------------------------------------------------------
`define HASRX_CTRL_EN 0
`define HASRX_CTRL_DLL 1
`define HASRX_ST_GS_MSB 3
`define HASRX_ST_CFGERR 4
`define HASRX_ST_FRMERR 5
`define HASRX_ST_ALIVE 6
`define HASRX_GS_OFF 4'h0
`define HASRX_GS_WAIT 4'h1
`define HASRX_GS_READY 4'ha
`define HASRX_RATE_96K 3'h5
`define HASRX_NSLOT_6 3'h3
`define HASRX_NSLOT_8 3'h4
`define HASRX_BITCNT_MAX 6'h3f

`endif

//--- verilog/hasrx_pkg.sv
// types and decode functions of the haptic audio serial receiver
`include "hasrx_cfg.svh"

package hasrx_pkg;

  // --------------------------------------------------------------------------
  // types
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    HASRX_OFF,
    HASRX_WAIT,
    HASRX_READY
  } hasrx_state_t;

  typedef struct packed {
    logic [`HASRX_FMT_W-1:0] fmt;
    logic [`HASRX_WID_W-1:0] wid;
    logic en;
    logic dll;
    hasrx_state_t state;
    logic cfg_err;
    logic frm_err;
    logic [31:0] sample;
    logic valid;
    logic [15:0] count;
    logic [`HASRX_DW-1:0] rdata;
    logic tog_d;
    logic ferr_d;
  } hasrx_core_t;

  typedef struct packed {
    logic run_d;
    logic [`HASRX_FMT_W-1:0] fmt;
    logic [`HASRX_WID_W-1:0] wid;
    logic wck_d;
    logic arm;
    logic active;
    logic [2:0] chan;
    logic [5:0] bit_cnt;
    logic [31:0] shreg;
    logic [31:0] hold;
    logic tog;
    logic ferr_tog;
    logic alive;
  } hasrx_link_t;

  // --------------------------------------------------------------------------
  // decode functions
  // --------------------------------------------------------------------------
  // 0:16 1:24 2,3:32 bits, shared by data width and slot length
  function automatic logic [5:0] hasrx_bits(input logic [1:0] code);
    unique case (code)
      2'h0: hasrx_bits = 6'h10;
      2'h1: hasrx_bits = 6'h18;
      default: hasrx_bits = 6'h20;
    endcase
  endfunction : hasrx_bits

  function automatic logic [3:0] hasrx_slots(input logic [2:0] code);
    unique case (code)
      3'h0: hasrx_slots = 4'h1;
      3'h1: hasrx_slots = 4'h2;
      3'h2: hasrx_slots = 4'h4;
      3'h3: hasrx_slots = 4'h6;
      default: hasrx_slots = 4'h8;
    endcase
  endfunction : hasrx_slots

endpackage : hasrx_pkg

//--- verilog/hasrx_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/10ps
`default_nettype none

module hasrx_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  // first stage feeds the second only
  always_ff @(posedge clk) begin
    meta_reg <= d;
    sync_reg <= meta_reg;
  end

  assign q = sync_reg;
endmodule : hasrx_sync

`default_nettype wire

//--- verilog/hasrx_link.sv
// bit clock domain receiver: framing, slot selection and sample capture
`timescale 1ns/10ps
`default_nettype none
`include "hasrx_cfg.svh"

module hasrx_link (
  input wire logic bit_clock,
  input wire logic run,
  input wire logic [`HASRX_FMT_W-1:0] fmt_in,
  input wire logic [`HASRX_WID_W-1:0] wid_in,
  input wire logic word_clock,
  input wire logic serial_data_in,
  output logic [31:0] hold_data,
  output logic sample_tog,
  output logic ferr_tog,
  output logic alive
);
  import hasrx_pkg::*;

  hasrx_link_t r_reg;
  hasrx_link_t r_next;

  // ----------------------------------------------------------------------------
  // framing
  // ----------------------------------------------------------------------------
  always_comb begin
    logic tdm;
    logic first_edge;
    logic start;
    logic take;
    logic [5:0] b;
    logic [5:0] wbits;
    logic [5:0] slen;
    logic [3:0] nsl;
    logic [2:0] sel;
    logic [31:0] val;
    tdm = r_reg.fmt[`HASRX_FMT_TDM];
    first_edge = r_reg.fmt[`HASRX_FMT_ALIGN];
    start = 1'b0;
    take = 1'b0;
    b = 6'h0;
    wbits = hasrx_bits(r_reg.wid[`HASRX_WID_SW_MSB:`HASRX_WID_SW_LSB]);
    slen = hasrx_bits(r_reg.wid[`HASRX_WID_SLEN_MSB:`HASRX_WID_SLEN_LSB]);
    nsl = tdm ? hasrx_slots(r_reg.fmt[`HASRX_FMT_NSLOT_MSB:`HASRX_FMT_NSLOT_LSB]) : 4'h2;
    sel = tdm ? r_reg.fmt[`HASRX_FMT_SEL_MSB:`HASRX_FMT_SEL_LSB]
              : {2'b00, r_reg.fmt[`HASRX_FMT_SEL_LSB]};
    val = 32'h0;
    r_next = r_reg;
    r_next.run_d = run;
    r_next.wck_d = word_clock;
    if (!run) begin
      r_next.arm = 1'b0;
      r_next.active = 1'b0;
      r_next.alive = 1'b0;
      // no reset here: toggles restart from zero so the core never inherits an unknown
      r_next.tog = 1'b0;
      r_next.ferr_tog = 1'b0;
    end else if (!r_reg.run_d) begin
      // config is captured here; the top's write gate holds it still while the core is not off
      r_next.fmt = fmt_in;
      r_next.wid = wid_in;
    end else begin
      // two-slot framing restarts on every word clock edge, tdm on rising only
      start = tdm ? (word_clock & ~r_reg.wck_d) : (word_clock ^ r_reg.wck_d);
      if (start) begin
        r_next.alive = 1'b1;
        if (tdm && r_reg.active && ({1'b0, r_reg.chan} != nsl - 4'h1)) begin
          r_next.ferr_tog = ~r_reg.ferr_tog;
        end
        if (tdm) begin
          r_next.chan = 3'h0;
        end else if (first_edge) begin
          r_next.chan = {2'b00, ~word_clock};
        end else begin
          r_next.chan = {2'b00, word_clock};
        end
        if (first_edge) begin
          take = 1'b1;
          r_next.active = 1'b1;
          r_next.arm = 1'b0;
        end else begin
          r_next.arm = 1'b1;
          r_next.active = 1'b0;
        end
      end else if (r_reg.arm) begin
        take = 1'b1;
        r_next.arm = 1'b0;
        r_next.active = 1'b1;
      end else if (r_reg.active && r_reg.bit_cnt != `HASRX_BITCNT_MAX) begin
        b = r_reg.bit_cnt + 6'h1;
        take = 1'b1;
        if (tdm && b == slen) begin
          b = 6'h0;
          if ({1'b0, r_reg.chan} == nsl - 4'h1) begin
            take = 1'b0;
            r_next.active = 1'b0;
          end else begin
            r_next.chan = r_reg.chan + 3'h1;
          end
        end
      end
      if (take) begin
        r_next.bit_cnt = b;
        if (b < wbits) begin
          val = (b == 6'h0) ? {31'h0, serial_data_in} : {r_reg.shreg[30:0], serial_data_in};
          r_next.shreg = val;
          if (b == wbits - 6'h1 && r_next.chan == sel && {1'b0, r_next.chan} < nsl) begin
            r_next.hold = val;
            r_next.tog = ~r_reg.tog;
          end
        end
      end
    end
  end

  always_ff @(posedge bit_clock) begin
    r_reg <= r_next;
  end

  assign hold_data = r_reg.hold;
  assign sample_tog = r_reg.tog;
  assign ferr_tog = r_reg.ferr_tog;
  assign alive = r_reg.alive;
endmodule : hasrx_link

`default_nettype wire

//--- verilog/hasrx_top.sv
// haptic audio serial receiver top: register port, enable sequence, sample hand-off
// ----------------------------------------------------------------------------
// Summary of operation
// - bit, word clock and data pins receive waves
// - slave only, clocks are never driven
// - sample width selectable 16, 24 or 32
// - two-slot or 1/2/4/6/8 slot tdm framing
// - format bit picks standard or left-justified
// - data sampled on bit clock; master sets rate
// - select left/right channel or tdm slot 1..8
// - enable sequence ends with global state ready
// - standard: low is left, msb second edge
// - left-justified: high is left, msb first edge
// - tdm slot 1 msb first or second edge
// ----------------------------------------------------------------------------
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "hasrx_cfg.svh"

module hasrx_top (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [`HASRX_AW-1:0] reg_addr,
  input wire logic [`HASRX_DW-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [`HASRX_DW-1:0] reg_rdata,
  input wire logic bit_clock,
  input wire logic word_clock,
  input wire logic serial_data_in,
  output logic [31:0] sample_data,
  output logic sample_valid,
  output logic [3:0] global_state,
  output logic dll_enable
);
  import hasrx_pkg::*;

  // ----------------------------------------------------------------------------
  // crossings
  // ----------------------------------------------------------------------------
  hasrx_core_t st_reg;
  hasrx_core_t st_next;
  logic run_link;
  logic [31:0] hold_data;
  logic sample_tog;
  logic ferr_tog;
  logic alive;
  logic [2:0] back_s;

  // enable level into the link domain; config words are captured there on its rise
  hasrx_sync #(.W(1)) u_run_sync (
    .clk(bit_clock),
    .d(st_reg.state != HASRX_OFF),
    .q(run_link)
  );

  // clocks enter as inputs only, nothing here drives them
  hasrx_link u_link (
    .bit_clock(bit_clock),
    .run(run_link),
    .fmt_in(st_reg.fmt),
    .wid_in(st_reg.wid),
    .word_clock(word_clock),
    .serial_data_in(serial_data_in),
    .hold_data(hold_data),
    .sample_tog(sample_tog),
    .ferr_tog(ferr_tog),
    .alive(alive)
  );

  // toggles and the alive level back to core; hold data sit still a whole slot
  hasrx_sync #(.W(3)) u_back_sync (
    .clk(core_clk),
    .d({alive, ferr_tog, sample_tog}),
    .q(back_s)
  );

  function automatic logic [3:0] hasrx_gs(input hasrx_state_t s);
    unique case (s)
      HASRX_OFF: hasrx_gs = `HASRX_GS_OFF;
      HASRX_WAIT: hasrx_gs = `HASRX_GS_WAIT;
      HASRX_READY: hasrx_gs = `HASRX_GS_READY;
      default: hasrx_gs = `HASRX_GS_OFF;
    endcase
  endfunction : hasrx_gs

  // ----------------------------------------------------------------------------
  // register file and sequence
  // ----------------------------------------------------------------------------
  always_comb begin
    logic bad_cfg;
    logic sample_evt;
    logic ferr_evt;
    bad_cfg = (st_reg.fmt[`HASRX_FMT_RATE_MSB:`HASRX_FMT_RATE_LSB] == `HASRX_RATE_96K)
              && st_reg.fmt[`HASRX_FMT_TDM]
              // every code from six slots up decodes to six or eight slots
              && (st_reg.fmt[`HASRX_FMT_NSLOT_MSB:`HASRX_FMT_NSLOT_LSB] >= `HASRX_NSLOT_6);
    sample_evt = (back_s[0] != st_reg.tog_d);
    ferr_evt = (back_s[1] != st_reg.ferr_d);
    st_next = st_reg;
    st_next.tog_d = back_s[0];
    st_next.ferr_d = back_s[1];
    st_next.valid = 1'b0;
    st_next.rdata = '0;
    if (reg_write) begin
      unique case (reg_addr)
        `HASRX_ADDR_FORMAT: begin
          // framing changes only while off, so the link never sees a word mid-change
          if (st_reg.state == HASRX_OFF) begin
            st_next.fmt = reg_wdata[`HASRX_FMT_W-1:0];
          end
        end
        `HASRX_ADDR_WIDTH: begin
          if (st_reg.state == HASRX_OFF) begin
            st_next.wid = reg_wdata[`HASRX_WID_W-1:0];
          end
        end
        `HASRX_ADDR_CTRL: begin
          st_next.en = reg_wdata[`HASRX_CTRL_EN];
          st_next.dll = reg_wdata[`HASRX_CTRL_DLL];
          if (!reg_wdata[`HASRX_CTRL_EN]) begin
            st_next.cfg_err = 1'b0;
          end
        end
        `HASRX_ADDR_STATUS: begin
          if (reg_wdata[`HASRX_ST_FRMERR]) begin
            st_next.frm_err = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // set wins over a clear in the same cycle
    if (ferr_evt && st_reg.state == HASRX_READY) begin
      st_next.frm_err = 1'b1;
    end
    unique case (st_reg.state)
      HASRX_OFF: begin
        if (st_reg.en && bad_cfg) begin
          st_next.cfg_err = 1'b1;
        end else if (st_reg.en) begin
          st_next.state = HASRX_WAIT;
        end
      end
      HASRX_WAIT: begin
        if (!st_reg.en) begin
          st_next.state = HASRX_OFF;
        end else if (back_s[2]) begin
          st_next.state = HASRX_READY;
        end
      end
      HASRX_READY: begin
        if (!st_reg.en) begin
          st_next.state = HASRX_OFF;
        end else if (sample_evt) begin
          st_next.sample = hold_data;
          st_next.valid = 1'b1;
          st_next.count = st_reg.count + 16'h1;
        end
      end
    endcase
    if (reg_read) begin
      unique case (reg_addr)
        `HASRX_ADDR_FORMAT: st_next.rdata = {17'h0, st_reg.fmt};
        `HASRX_ADDR_WIDTH: st_next.rdata = {28'h0, st_reg.wid};
        `HASRX_ADDR_CTRL: st_next.rdata = {30'h0, st_reg.dll, st_reg.en};
        `HASRX_ADDR_STATUS: st_next.rdata = {25'h0, back_s[2], st_reg.frm_err, st_reg.cfg_err,
                                             hasrx_gs(st_reg.state)};
        `HASRX_ADDR_SAMPLE: st_next.rdata = st_reg.sample;
        `HASRX_ADDR_COUNT: st_next.rdata = {16'h0, st_reg.count};
        default: st_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_reg <= '{fmt: `HASRX_FMT_RESET, wid: `HASRX_WID_RESET, state: HASRX_OFF, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata = st_reg.rdata;
  assign sample_data = st_reg.sample;
  assign sample_valid = st_reg.valid;
  assign global_state = hasrx_gs(st_reg.state);
  assign dll_enable = st_reg.dll;
endmodule : hasrx_top

`default_nettype wire

//--- tb/hasrx_properties.sv
// assertion checker on the receiver core clock ports
`timescale 1ns/10ps
`default_nettype none
`include "hasrx_cfg.svh"

module hasrx_checker (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [`HASRX_AW-1:0] reg_addr,
  input wire logic [`HASRX_DW-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [`HASRX_DW-1:0] reg_rdata,
  input wire logic bit_clock,
  input wire logic word_clock,
  input wire logic serial_data_in,
  input wire logic [31:0] sample_data,
  input wire logic sample_valid,
  input wire logic [3:0] global_state,
  input wire logic dll_enable
);
  // ------------------------------------
  // shadow of the locked configuration
  // ------------------------------------
  // config is only taken while off, so the shadow follows the same gate
  logic [1:0] wsel_reg;
  logic bad_reg;
  logic wr_off;
  logic [5:0] wbits;
  assign wr_off = reg_write && global_state == `HASRX_GS_OFF;
  assign wbits = wsel_reg == 2'h0 ? 6'h10 : (wsel_reg == 2'h1 ? 6'h18 : 6'h20);
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wsel_reg <= 2'h0;
      bad_reg <= 1'b0;
    end else if (wr_off && reg_addr == `HASRX_ADDR_WIDTH) begin
      wsel_reg <= reg_wdata[1:0];
    end else if (wr_off && reg_addr == `HASRX_ADDR_FORMAT) begin
      bad_reg <= reg_wdata[0] && reg_wdata[14:12] == 3'h5 && reg_wdata[10:8] >= 3'h3;
    end
  end

  // ------------------------------------
  // properties
  // ------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  property p_off;
    // state follows the registered enable one edge after it is written
    reg_write && reg_addr == `HASRX_ADDR_CTRL && !reg_wdata[0] |-> ##2 global_state == 4'h0;
  endproperty
  a_off: assert property (p_off) else $error("not off after disable");

  property p_wait;
    reg_write && reg_addr == `HASRX_ADDR_CTRL && reg_wdata[0] && !bad_reg
      && global_state == 4'h0 |-> ##[1:2] global_state == 4'h1;
  endproperty
  a_wait: assert property (p_wait) else $error("no wait state after enable");

  property p_ready;
    $rose(global_state == 4'ha) |-> $past(global_state) == 4'h1;
  endproperty
  a_ready: assert property (p_ready) else $error("ready not entered from wait");

  property p_bad;
    reg_write && reg_addr == `HASRX_ADDR_CTRL && reg_wdata[0] && bad_reg
      && global_state == 4'h0 |=> (global_state == 4'h0) [*4];
  endproperty
  a_bad: assert property (p_bad) else $error("bad config left off state");

  property p_vready;
    sample_valid |-> global_state == 4'ha;
  endproperty
  a_vready: assert property (p_vready) else $error("sample outside ready");

  property p_pulse;
    sample_valid |=> !sample_valid;
  endproperty
  a_pulse: assert property (p_pulse) else $error("sample pulse too long");

  property p_width;
    sample_valid |-> (sample_data >> wbits) == 32'h0;
  endproperty
  a_width: assert property (p_width) else $error("bits above width");

  property p_rdata;
    !reg_read |=> reg_rdata == 32'h0;
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data without read");
endmodule : hasrx_checker

bind hasrx_top hasrx_checker u_chk (
  .core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
  .bit_clock, .word_clock, .serial_data_in, .sample_data, .sample_valid,
  .global_state, .dll_enable
);
`default_nettype wire

//--- tb/hasrx_master.sv
// serial audio master model: bit clock, word clock and data
`timescale 1ns/10ps
`default_nettype none

module hasrx_master (
  output logic bit_clock,
  output logic word_clock,
  output logic serial_data_in
);
  initial begin
    bit_clock = 1'b0;
    word_clock = 1'b0;
    serial_data_in = 1'b0;
  end

  // ------------------------------------
  // bit and frame drivers
  // ------------------------------------
  // both clocks come from here only; offset keeps bit clock edges off the core clock
  task automatic tick(input logic w, input logic d);
    word_clock = w;
    serial_data_in = d;
    #31.1 bit_clock = 1'b1;
    #62.5 bit_clock = 1'b0;
    #31.4;
  endtask : tick

  // idle parks the word clock low so every frame starts from a known level
  task automatic idle(input int n);
    repeat (n) tick(1'b0, ~serial_data_in);
  endtask : idle

  // a set: left-justified or first-edge tdm, else data lags one bit
  task automatic frame(input logic tdm, input logic a, input int nsl, input int slen,
                       input int w, input logic [31:0] base);
    logic [31:0] word;
    int j;
    for (int i = 0; i < nsl * slen + !a; i++) begin
      j = i - !a;
      word = base + (j / slen) * 32'h01010101;
      tick(tdm ? i == 0 : (i / slen == 0) == a,
           (j < 0 || j % slen >= w) ? 1'b1 : word[w - 1 - j % slen]);
    end
    // clock stops; data no longer holds its last value
    serial_data_in = ~serial_data_in;
  endtask : frame
endmodule : hasrx_master
`default_nettype wire

//--- tb/testbench.sv
// self-checking bench of the haptic audio serial receiver
`timescale 1ns/10ps
`default_nettype none
`include "hasrx_cfg.svh"

`define CHK(act, exp) \
  begin \
    compares++; \
    if ((act) !== (exp)) begin \
      num_errors++; \
      $display("Error at %0t: got %h expected %h", $time, act, exp); \
    end \
  end

module testbench;
  logic core_clk;
  logic rst_n;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_write;
  logic reg_read;
  logic [31:0] reg_rdata;
  logic bit_clock;
  logic word_clock;
  logic serial_data_in;
  logic [31:0] sample_data;
  logic sample_valid;
  logic [3:0] global_state;
  logic dll_enable;
  logic [31:0] got;
  logic [31:0] st;
  int n_smp;
  int num_errors;
  int compares;

  hasrx_top uut (
    .core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .bit_clock, .word_clock, .serial_data_in, .sample_data, .sample_valid,
    .global_state, .dll_enable
  );
  hasrx_master m (.bit_clock, .word_clock, .serial_data_in);

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // ------------------------------------
  // bus and sample helpers
  // ------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    @(negedge core_clk);
    st = reg_rdata;
  endtask : rd

  task automatic look;
    @(negedge core_clk);
    if (sample_valid === 1'b1) begin
      n_smp++;
      got = sample_data;
    end
  endtask : look

  // warm-up frame brings the link alive; only the second frame is judged
  task automatic play(input logic [14:0] f, input logic [3:0] wd, input int nsl,
                      input int slen, input int w, input logic [31:0] base, input int sel);
    bit done;
    logic [31:0] exp_smp;
    done = 1'b0;
    exp_smp = (base + sel * 32'h01010101) & (32'hffffffff >> (32 - w));
    wr(`HASRX_ADDR_CTRL, 32'h0);
    m.idle(4);
    wr(`HASRX_ADDR_FORMAT, {17'h0, f});
    wr(`HASRX_ADDR_WIDTH, {28'h0, wd});
    wr(`HASRX_ADDR_CTRL, 32'h3);
    // the link needs a few bit clocks to see the enable and latch its config
    m.idle(6);
    m.frame(f[0], f[1], nsl, slen, w, base);
    for (int i = 0; i < 400 && global_state !== `HASRX_GS_READY; i++) look;
    repeat (8) look;
    rd(`HASRX_ADDR_STATUS);
    `CHK(st[3:0], `HASRX_GS_READY)
    `CHK(st[6:4], 3'h4)
    `CHK(dll_enable, 1'b1)
    n_smp = 0;
    fork
      begin
        m.frame(f[0], f[1], nsl, slen, w, base);
        done = 1'b1;
      end
      while (!done) look;
    join
    repeat (8) look;
    `CHK(n_smp, 1)
    `CHK(got, exp_smp)
    rd(`HASRX_ADDR_SAMPLE);
    `CHK(st, exp_smp)
  endtask : play

  // ------------------------------------
  // scenarios
  // ------------------------------------
  task automatic t_reset;
    `CHK(global_state, `HASRX_GS_OFF)
    `CHK(dll_enable, 1'b0)
    rd(`HASRX_ADDR_STATUS);
    `CHK(st[5:0], 6'h0)
  endtask : t_reset

  // slot codes above six decode to eight slots and are refused at 96k too
  task automatic t_cfg_err;
    for (int k = 3; k < 8; k++) begin
      wr(`HASRX_ADDR_FORMAT, 32'h5001 | (k << 8));
      wr(`HASRX_ADDR_CTRL, 32'h1);
      repeat (4) @(negedge core_clk);
      rd(`HASRX_ADDR_STATUS);
      `CHK(st[4:0], 5'h10)
      wr(`HASRX_ADDR_CTRL, 32'h0);
    end
  endtask : t_cfg_err

  task automatic t_lj;
    play(15'h3002, 4'h0, 2, 16, 16, 32'h12348421, 0);
  endtask : t_lj

  task automatic t_std;
    play(15'h1010, 4'h1, 2, 32, 24, 32'ha5c396e1, 1);
  endtask : t_std

  task automatic t_tdm8;
    play(15'h4471, 4'ha, 8, 32, 32, 32'h8badf00d, 7);
  endtask : t_tdm8

  task automatic t_tdm6;
    play(15'h2323, 4'h9, 6, 32, 24, 32'h0f1e2d3c, 2);
  endtask : t_tdm6

  // 96k stays legal up to four slots
  task automatic t_tdm_small;
    for (int c = 0; c < 3; c++) begin
      play(15'h5003 | (c << 8) | (((1 << c) - 1) << 4), 4'h0, 1 << c, 16, 16,
           32'h13579bdf + c, (1 << c) - 1);
    end
  endtask : t_tdm_small

  // four slots configured, frames of two: the second start comes too early
  task automatic t_frm_err;
    m.frame(1'b1, 1'b1, 2, 16, 16, 32'h0);
    m.frame(1'b1, 1'b1, 2, 16, 16, 32'h0);
    repeat (4) look;
    rd(`HASRX_ADDR_STATUS);
    `CHK(st[5], 1'b1)
    wr(`HASRX_ADDR_STATUS, 32'h20);
    rd(`HASRX_ADDR_STATUS);
    `CHK(st[5], 1'b0)
  endtask : t_frm_err

  task automatic report_and_stop;
    if (num_errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #2000000;
    num_errors++;
    report_and_stop;
  end

  initial begin
    rst_n = 1'b0;
    reg_addr = 8'h0;
    reg_wdata = 32'h0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    num_errors = 0;
    compares = 0;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    m.idle(8);
    t_reset;
    t_cfg_err;
    t_lj;
    t_std;
    t_tdm8;
    t_tdm6;
    t_tdm_small;
    t_frm_err;
    report_and_stop;
  end
endmodule : testbench
`default_nettype wire
